//--- dpsa_top.sv
// debug port select, key acquisition and pin gating
//
// What this block does
// - on-chip debug circuits start off; only a firmware register write turns them on
// - once off, debug returns only after erase and new firmware that turns it on
// - scan port pins come up enabled; a control bit returns them to gpio
// - scan port runs on four pins; the test-reset pin is optional
// - scan port serves board test, daisy chains, flash programming and debug
// - serial debug sits on scan mode/clock pins or the usb data pins
// - serial debug: one pin is tool clock, the other is two-way data
// - serial debug is active on at most one pin pair at a time
// - serial debug is claimed by a key on a pair within 8 us, or by a scan port request on the scan pair
// - serial debug gives programming and debug but no scan chains
// - serial debug can be enabled from the scan port, or released to gpio
// - a key in the window claims serial debug when it is free and unlocked; serial debug can re-enable the scan port
// - security lock disables every programming, debug and test interface for good
// - trace leaves on the scan data-out pin only while serial debug is selected
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module dpsa_top #(
  parameter int KEY_LEN = dpsa_pkg::DPSA_KEY_LEN,
  parameter logic [KEY_LEN-1:0] KEY_PAT = dpsa_pkg::DPSA_KEY_PAT,
  parameter bit HAS_TRST = 1'b1
) (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // scan-port clock from the tool (link domain)
  input wire logic jtag_tck_clk_in,
  // device pins: tms, tck, tdi, tdo, trst, usb d+, usb d-
  input wire logic [dpsa_pkg::DPSA_NUM_PINS-1:0] pin_in,
  output logic [dpsa_pkg::DPSA_NUM_PINS-1:0] pin_out,
  output logic [dpsa_pkg::DPSA_NUM_PINS-1:0] pin_oe_out,
  // gpio function of the same pins
  input wire logic [dpsa_pkg::DPSA_NUM_PINS-1:0] gpio_out_in,
  input wire logic [dpsa_pkg::DPSA_NUM_PINS-1:0] gpio_oe_in,
  // security latch level
  input wire logic secure_lock_in,
  // scan engine side
  input wire logic jtag_tdo_in,
  input wire logic jtag_tdo_oe_in,
  input wire logic jtag_req_swd_en_in,
  output logic jtag_active_out,
  output logic jtag_scan_en_out,
  output logic jtag_trst_b_out,
  // serial debug engine side
  input wire logic swd_dout_in,
  input wire logic swd_doe_in,
  input wire logic swd_req_jtag_en_in,
  input wire logic trace_in,
  output logic swd_active_out,
  output logic swd_on_usb_out,
  output logic swd_clk_rise_out,
  output logic swd_din_out,
  // debug circuits
  output logic on_chip_debug_circuits_out
);
  import dpsa_pkg::*;

  localparam logic [DPSA_WIN_CNT_W-1:0] WIN_LAST = DPSA_WIN_CNT_W'(DPSA_KEY_WIN_CYC);

  // ---------------- pin synchronisers ----------------
  logic [DPSA_NUM_PINS-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // tool clock edges, oversampled (tool clock kept under cpu/3)
  logic tck_rise, dm_rise;
  assign tck_rise = pin_s2_q[DPSA_PIN_TCK] & ~pin_s3_q[DPSA_PIN_TCK];
  assign dm_rise = pin_s2_q[DPSA_PIN_DM] & ~pin_s3_q[DPSA_PIN_DM];

  // ---------------- key window after reset ----------------
  logic [DPSA_WIN_CNT_W-1:0] win_cnt_q;
  logic win_open_q;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_cnt_q <= '0;
      win_open_q <= 1'b1;
    end else if (win_open_q) begin
      win_cnt_q <= win_cnt_q + DPSA_WIN_CNT_W'(1);
      if (win_cnt_q == WIN_LAST - DPSA_WIN_CNT_W'(1)) begin
        win_open_q <= 1'b0;
      end
    end
  end

  // ---------------- security latch, sampled after release ----------------
  logic lock_s1_q, lock_s2_q, lock_q;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= secure_lock_in;
      lock_s2_q <= lock_s1_q;
    end
  end

  // taken once per reset; held locked until then
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_q <= DPSA_LOCK_RST;
    end else if (win_open_q && win_cnt_q == DPSA_LOCK_SAMPLE_CYC) begin
      lock_q <= lock_s2_q;
    end
  end

  // ---------------- key detect on the scan pair (link domain) ----------------
  logic win_l1_q, win_l2_q;
  logic [KEY_LEN-1:0] jkey_sh_q;
  logic jkey_tgl_q;
  always_ff @(posedge jtag_tck_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_l1_q <= 1'b0;
      win_l2_q <= 1'b0;
    end else begin
      win_l1_q <= win_open_q;
      win_l2_q <= win_l1_q;
    end
  end

  // tms shifted on tck while the window is open
  always_ff @(posedge jtag_tck_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      jkey_sh_q <= '0;
    end else if (win_l2_q) begin
      jkey_sh_q <= {jkey_sh_q[KEY_LEN-2:0], pin_in[DPSA_PIN_TMS]};
    end
  end

  always_ff @(posedge jtag_tck_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      jkey_tgl_q <= 1'b0;
    end else if (win_l2_q && {jkey_sh_q[KEY_LEN-2:0], pin_in[DPSA_PIN_TMS]} == KEY_PAT) begin
      // hit on the edge that shifts in the last bit; tck may stop right after
      jkey_tgl_q <= ~jkey_tgl_q;
    end
  end

  // toggle back into the system domain
  logic jtgl_s1_q, jtgl_s2_q, jtgl_s3_q;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      jtgl_s1_q <= 1'b0;
      jtgl_s2_q <= 1'b0;
      jtgl_s3_q <= 1'b0;
    end else begin
      jtgl_s1_q <= jkey_tgl_q;
      jtgl_s2_q <= jtgl_s1_q;
      jtgl_s3_q <= jtgl_s2_q;
    end
  end

  logic jkey_hit;
  assign jkey_hit = jtgl_s2_q ^ jtgl_s3_q;

  // ---------------- key detect on the usb pair (system domain) ----------------
  logic [KEY_LEN-1:0] ukey_sh_q;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ukey_sh_q <= '0;
    end else if (win_open_q && dm_rise) begin
      ukey_sh_q <= {ukey_sh_q[KEY_LEN-2:0], pin_s2_q[DPSA_PIN_DP]};
    end
  end

  // one-cycle hit on the d- edge that completes the key, window open only
  logic ukey_hit;
  assign ukey_hit = win_open_q && dm_rise
    && {ukey_sh_q[KEY_LEN-2:0], pin_s2_q[DPSA_PIN_DP]} == KEY_PAT;

  // ---------------- apb control register ----------------
  logic apb_setup, apb_wr, ctrl_hit, stat_hit;
  assign apb_setup = psel_in & ~penable_in;
  assign ctrl_hit = paddr_in == DPSA_CTRL_OFS;
  assign stat_hit = paddr_in == DPSA_STAT_OFS;
  assign apb_wr = psel_in & penable_in & pwrite_in & ctrl_hit;
  assign pready_out = 1'b1;

  logic dbg_en_q, jtag_dis_q, swd_rel;
  dpsa_swd_sel_e swd_sel_q, swd_sel_d;
  assign swd_rel = apb_wr & pwdata_in[DPSA_CTRL_SWD_REL];

  // firmware can only turn debug on; only reset turns it off
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dbg_en_q <= DPSA_DBG_EN_RST;
    end else if (apb_wr && pwdata_in[DPSA_CTRL_DBG_EN]) begin
      dbg_en_q <= 1'b1;
    end
  end

  // serial debug's re-enable wins over a same-cycle disable write
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      jtag_dis_q <= DPSA_JTAG_DIS_RST;
    end else if (swd_sel_q != DPSA_SWD_OFF && swd_req_jtag_en_in) begin
      jtag_dis_q <= 1'b0;
    end else if (apb_wr) begin
      jtag_dis_q <= pwdata_in[DPSA_CTRL_JTAG_DIS];
    end
  end

  // ---------------- serial debug ownership ----------------
  always_comb begin
    swd_sel_d = swd_sel_q;
    case (swd_sel_q)
      DPSA_SWD_OFF: begin
        if (jkey_hit) begin
          swd_sel_d = DPSA_SWD_JTAG_PAIR;
        end else if (ukey_hit) begin
          swd_sel_d = DPSA_SWD_USB_PAIR;
        end else if (jtag_req_swd_en_in && !jtag_dis_q) begin
          swd_sel_d = DPSA_SWD_JTAG_PAIR;
        end else begin
          swd_sel_d = DPSA_SWD_OFF;
        end
      end
      DPSA_SWD_JTAG_PAIR, DPSA_SWD_USB_PAIR: begin
        // a claim in the same cycle beats the release; never both pairs
        if (swd_rel && !jkey_hit && !ukey_hit) begin
          swd_sel_d = DPSA_SWD_OFF;
        end
      end
      default: swd_sel_d = DPSA_SWD_OFF;
    endcase
    if (lock_q) begin
      swd_sel_d = DPSA_SWD_OFF;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      swd_sel_q <= DPSA_SWD_OFF;
    end else begin
      swd_sel_q <= swd_sel_d;
    end
  end

  logic swd_act, swd_usb, swd_jpair, jtag_act;
  assign swd_act = swd_sel_q != DPSA_SWD_OFF;
  assign swd_usb = swd_sel_q == DPSA_SWD_USB_PAIR;
  assign swd_jpair = swd_sel_q == DPSA_SWD_JTAG_PAIR;
  // scan port yields its pair to serial debug
  assign jtag_act = !jtag_dis_q && !swd_jpair && !lock_q;

  // ---------------- engine-side outputs ----------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      jtag_active_out <= 1'b0;
      jtag_scan_en_out <= 1'b0;
      jtag_trst_b_out <= 1'b0;
      swd_active_out <= 1'b0;
      swd_on_usb_out <= 1'b0;
      swd_clk_rise_out <= 1'b0;
      swd_din_out <= 1'b0;
      on_chip_debug_circuits_out <= 1'b0;
    end else begin
      jtag_active_out <= jtag_act;
      // scan chains only through the scan port
      jtag_scan_en_out <= jtag_act;
      // optional fifth pin, else held released while active
      jtag_trst_b_out <= jtag_act && (!HAS_TRST || pin_s2_q[DPSA_PIN_TRST]);
      swd_active_out <= swd_act;
      swd_on_usb_out <= swd_usb;
      // clock pin and data pin of the selected pair
      swd_clk_rise_out <= swd_usb ? dm_rise : (swd_jpair && tck_rise);
      swd_din_out <= swd_usb ? pin_s2_q[DPSA_PIN_DP] : pin_s2_q[DPSA_PIN_TMS];
      on_chip_debug_circuits_out <= dbg_en_q && !lock_q;
    end
  end

  // ---------------- pin muxing ----------------
  logic [DPSA_NUM_PINS-1:0] dbg_own, dbg_val, dbg_oe;
  always_comb begin
    dbg_own = '0;
    dbg_val = '0;
    dbg_oe = '0;
    if (jtag_act) begin
      // four or five pins; trst left to gpio when absent
      dbg_own[DPSA_PIN_TMS] = 1'b1;
      dbg_own[DPSA_PIN_TCK] = 1'b1;
      dbg_own[DPSA_PIN_TDI] = 1'b1;
      dbg_own[DPSA_PIN_TDO] = 1'b1;
      dbg_own[DPSA_PIN_TRST] = HAS_TRST;
      dbg_val[DPSA_PIN_TDO] = jtag_tdo_in;
      dbg_oe[DPSA_PIN_TDO] = jtag_tdo_oe_in;
    end
    if (swd_jpair) begin
      // tck is the clock input, tms the two-way data
      dbg_own[DPSA_PIN_TMS] = 1'b1;
      dbg_own[DPSA_PIN_TCK] = 1'b1;
      dbg_val[DPSA_PIN_TMS] = swd_dout_in;
      dbg_oe[DPSA_PIN_TMS] = swd_doe_in;
    end
    if (swd_usb) begin
      dbg_own[DPSA_PIN_DP] = 1'b1;
      dbg_own[DPSA_PIN_DM] = 1'b1;
      dbg_val[DPSA_PIN_DP] = swd_dout_in;
      dbg_oe[DPSA_PIN_DP] = swd_doe_in;
    end
    if (swd_act && !jtag_act) begin
      // trace on the data-out pin only without the scan port
      dbg_own[DPSA_PIN_TDO] = 1'b1;
      dbg_val[DPSA_PIN_TDO] = trace_in;
      dbg_oe[DPSA_PIN_TDO] = 1'b1;
    end
  end

  // each pin falls back to gpio when no debug function owns it
  genvar gi;
  generate
    for (gi = 0; gi < DPSA_NUM_PINS; gi++) begin : g_pin
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pin_out[gi] <= 1'b0;
          pin_oe_out[gi] <= 1'b0;
        end else begin
          pin_out[gi] <= dbg_own[gi] ? dbg_val[gi] : gpio_out_in[gi];
          pin_oe_out[gi] <= dbg_own[gi] ? dbg_oe[gi] : gpio_oe_in[gi];
        end
      end
    end
  endgenerate

  // ---------------- apb read data and error ----------------
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[DPSA_STAT_DBG_EN] = dbg_en_q;
    stat_word[DPSA_STAT_JTAG_ACT] = jtag_act;
    stat_word[DPSA_STAT_SWD_ACT] = swd_act;
    stat_word[DPSA_STAT_SWD_USB] = swd_usb;
    stat_word[DPSA_STAT_WIN] = win_open_q;
    stat_word[DPSA_STAT_LOCK] = lock_q;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end else if (apb_setup) begin
      pslverr_out <= !(ctrl_hit || stat_hit);
      if (!pwrite_in && ctrl_hit) begin
        prdata_out <= {{(32-DPSA_CTRL_W){1'b0}}, 1'b0, jtag_dis_q, dbg_en_q};
      end else if (!pwrite_in && stat_hit) begin
        prdata_out <= stat_word;
      end else begin
        prdata_out <= '0;
      end
    end
  end

endmodule

//--- dpsa_pkg.sv
// constants for the debug port select and acquire block
package dpsa_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] DPSA_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPSA_STAT_OFS = 8'h04;

  // control register fields
  localparam int DPSA_CTRL_DBG_EN = 0;
  localparam int DPSA_CTRL_JTAG_DIS = 1;
  localparam int DPSA_CTRL_SWD_REL = 2;
  localparam int DPSA_CTRL_W = 3;

  // status register fields
  localparam int DPSA_STAT_DBG_EN = 0;
  localparam int DPSA_STAT_JTAG_ACT = 1;
  localparam int DPSA_STAT_SWD_ACT = 2;
  localparam int DPSA_STAT_SWD_USB = 3;
  localparam int DPSA_STAT_WIN = 4;
  localparam int DPSA_STAT_LOCK = 5;

  // reset values
  localparam logic DPSA_DBG_EN_RST = 1'b0;
  localparam logic DPSA_JTAG_DIS_RST = 1'b0;
  localparam logic DPSA_LOCK_RST = 1'b1;

  // pin positions on the pin vector
  localparam int DPSA_NUM_PINS = 7;
  localparam int DPSA_PIN_TMS = 0;
  localparam int DPSA_PIN_TCK = 1;
  localparam int DPSA_PIN_TDI = 2;
  localparam int DPSA_PIN_TDO = 3;
  localparam int DPSA_PIN_TRST = 4;
  localparam int DPSA_PIN_DP = 5;
  localparam int DPSA_PIN_DM = 6;

  // timing
  localparam int DPSA_SYS_CLK_HZ = 125_000_000;
  localparam int DPSA_KEY_WIN_NS = 8000;
  localparam int DPSA_KEY_WIN_CYC = (DPSA_KEY_WIN_NS * (DPSA_SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int DPSA_WIN_CNT_W = 11;
  localparam logic [DPSA_WIN_CNT_W-1:0] DPSA_LOCK_SAMPLE_CYC = 11'h002;

  // key pattern defaults (arbitrary value)
  localparam int DPSA_KEY_LEN = 16;
  localparam logic [DPSA_KEY_LEN-1:0] DPSA_KEY_PAT = 16'ha5c3;

  // which serial debug pair owns the port
  typedef enum logic [1:0] {
    DPSA_SWD_OFF = 2'b00,
    DPSA_SWD_JTAG_PAIR = 2'b01,
    DPSA_SWD_USB_PAIR = 2'b10
  } dpsa_swd_sel_e;

endpackage

//--- dpsa_monitor.sv
// assertion checker for the debug port select and acquire block
`timescale 1ns/1ps
module dpsa_monitor
  import dpsa_pkg::*;
(
  // clock, reset and apb
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  // pins, lock and status outputs
  input wire logic secure_lock_in,
  input wire logic trace_in,
  input wire logic jtag_req_swd_en_in,
  input wire logic [DPSA_NUM_PINS-1:0] pin_out,
  input wire logic [DPSA_NUM_PINS-1:0] pin_oe_out,
  input wire logic jtag_active_out,
  input wire logic jtag_scan_en_out,
  input wire logic jtag_trst_b_out,
  input wire logic swd_active_out,
  input wire logic swd_on_usb_out,
  input wire logic on_chip_debug_circuits_out
);
  logic [10:0] cyc_q;
  logic wr_dbg;
  logic wr_rel;
  logic swd_only;
  assign wr_dbg = psel_in && penable_in && pwrite_in && paddr_in == DPSA_CTRL_OFS
    && pwdata_in[DPSA_CTRL_DBG_EN];
  assign wr_rel = psel_in && penable_in && pwrite_in && paddr_in == DPSA_CTRL_OFS
    && pwdata_in[DPSA_CTRL_SWD_REL];
  assign swd_only = swd_active_out && !jtag_active_out;
  // cycles since reset release, saturating
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc_q <= 11'h000;
    end else if (cyc_q != 11'h7ff) begin
      cyc_q <= cyc_q + 11'h001;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_debug_needs_write: assert property (
    $rose(on_chip_debug_circuits_out) |-> $past(wr_dbg) || $past(wr_dbg, 2))
    else $error("debug circuits came on without a control write");
  a_lock_kills_ports: assert property (
    secure_lock_in && cyc_q > 11'h008 |-> !jtag_active_out && !swd_active_out
    && !on_chip_debug_circuits_out)
    else $error("a port is usable while locked");
  a_jtag_on_default: assert property (
    cyc_q == 11'h008 && !secure_lock_in |-> jtag_active_out)
    else $error("scan port not enabled after reset");
  a_one_swd_pair: assert property (
    swd_active_out && $past(swd_active_out) |-> $stable(swd_on_usb_out))
    else $error("serial debug moved to the other pair while owned");
  a_scan_needs_jtag: assert property (
    jtag_scan_en_out == jtag_active_out)
    else $error("scan chain enable differs from scan port ownership");
  a_trace_on_tdo: assert property (
    $past(swd_only) && swd_only |-> pin_oe_out[DPSA_PIN_TDO]
    && pin_out[DPSA_PIN_TDO] == $past(trace_in))
    else $error("trace not driven on data-out pin");
  a_claim_in_window: assert property (
    $rose(swd_active_out) && !$past(jtag_req_swd_en_in, 2) |-> cyc_q < 11'd1040)
    else $error("serial debug claimed after the key window");
  a_trst_gated: assert property (
    jtag_trst_b_out |-> jtag_active_out || $past(jtag_active_out))
    else $error("test reset released while scan port inactive");
  a_release_by_write: assert property (
    $fell(swd_active_out) |-> $past(wr_rel) || $past(wr_rel, 2))
    else $error("serial debug dropped without a release write");
endmodule

//--- dpsa_probe.sv
// external debug probe model sending a key on either pin pair
`timescale 1ns/1ps
module dpsa_probe (
  // scan pair
  output logic tck_out,
  output logic tms_out,
  // usb pair, d- clock and d+ data
  output logic dm_out,
  output logic dp_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b0;
    dm_out = 1'b0;
    dp_out = 1'b1;
  end
  // 64 ns bit clock, under a third of cpu clock; clock stands low outside frames
  task automatic send_key(input logic usb, input logic [15:0] pat);
    #13;
    for (int i = 15; i >= 0; i--) begin
      dp_out = usb ? pat[i] : dp_out;
      tms_out = usb ? tms_out : pat[i];
      #32;
      dm_out = usb;
      tck_out = !usb;
      #32;
      dm_out = 1'b0;
      tck_out = 1'b0;
    end
    // released data line shows the inverse, never a held value
    dp_out = usb ? ~pat[0] : dp_out;
    tms_out = usb ? tms_out : ~pat[0];
  endtask
endmodule

//--- dpsa_top_bench.sv
// self-checking bench for the debug port select and acquire block
`timescale 1ns/1ps
module dpsa_top_bench;
  import dpsa_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic pready_out, pslverr_out, tck, tms, dm, dp;
  logic [6:0] pin_out, pin_oe_out, gpio_out_in = 7'h55, gpio_oe_in = 7'h1c;
  logic secure_lock_in = 1'b0, trace_in = 1'b0;
  logic jtag_req_swd_en_in = 1'b0, swd_req_jtag_en_in = 1'b0;
  logic jtag_active_out, jtag_scan_en_out, jtag_trst_b_out, swd_active_out;
  logic swd_on_usb_out, swd_clk_rise_out, swd_din_out, on_chip_debug_circuits_out;
  wire logic [6:0] pin_in;
  int failures = 0, num_checks = 0, cycles = 0;
  // wire level: driven pins show the design, the rest the probe or fixed tdi/tdo/trst levels
  assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & {dm, dp, 3'b100, tck, tms});
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    trace_in <= ~trace_in;
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  dpsa_probe probe (.tck_out(tck), .tms_out(tms), .dm_out(dm), .dp_out(dp));
  dpsa_top DUT (.sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .jtag_tck_clk_in(tck), .pin_in,
    .pin_out, .pin_oe_out, .gpio_out_in, .gpio_oe_in, .secure_lock_in, .jtag_tdo_in(1'b1),
    .jtag_tdo_oe_in(1'b1), .jtag_req_swd_en_in, .jtag_active_out, .jtag_scan_en_out,
    .jtag_trst_b_out, .swd_dout_in(1'b1), .swd_doe_in(1'b1), .swd_req_jtag_en_in,
    .trace_in, .swd_active_out, .swd_on_usb_out, .swd_clk_rise_out, .swd_din_out,
    .on_chip_debug_circuits_out);
  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wdata;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rdata = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, data, d, e);
  endtask
  task automatic stat(input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    logic e;
    apb(1'b0, DPSA_STAT_OFS, 32'h0, d, e);
    check("status", exp, d & mask);
  endtask
  task automatic key(input logic usb, input logic [15:0] pat);
    probe.send_key(usb, pat);
    repeat (10) @(posedge sys_clk_in);
  endtask
  task automatic pulse_jtag_en();
    @(posedge sys_clk_in);
    swd_req_jtag_en_in <= 1'b1;
    @(posedge sys_clk_in);
    swd_req_jtag_en_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic do_reset(input logic lock);
    rst_b_in <= 1'b0;
    secure_lock_in <= lock;
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
  endtask
  initial begin
    logic [31:0] d;
    logic e;
    do_reset(1'b0);
    stat(32'h12, 32'h3f);
    apb(1'b0, 8'h08, 32'h0, d, e);
    check("unmapped read", 32'h1, {d[30:0], e});
    key(1'b1, DPSA_KEY_PAT);
    stat(32'h1e, 32'h3f);
    check("data pin", 32'h1, {31'h0, swd_din_out});
    key(1'b0, DPSA_KEY_PAT);
    key(1'b0, DPSA_KEY_PAT);
    stat(32'h1e, 32'h3f);
    wr(DPSA_CTRL_OFS, 32'h2);
    repeat (4) @(posedge sys_clk_in);
    stat(32'h0c, 32'h0e);
    check("tms gpio", {31'h0, gpio_out_in[0]}, {31'h0, pin_out[0]});
    pulse_jtag_en();
    stat(32'h0e, 32'h0e);
    wr(DPSA_CTRL_OFS, 32'h4);
    repeat (4) @(posedge sys_clk_in);
    stat(32'h02, 32'h0e);
    check("d+ gpio", {31'h0, gpio_oe_in[5]}, {31'h0, pin_oe_out[5]});
    repeat (1100) @(posedge sys_clk_in);
    key(1'b0, DPSA_KEY_PAT);
    stat(32'h02, 32'h1e);
    @(posedge sys_clk_in);
    jtag_req_swd_en_in <= 1'b1;
    @(posedge sys_clk_in);
    jtag_req_swd_en_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    stat(32'h04, 32'h0c);
    do_reset(1'b0);
    key(1'b0, ~DPSA_KEY_PAT);
    stat(32'h02, 32'h0e);
    key(1'b0, DPSA_KEY_PAT);
    stat(32'h04, 32'h0e);
    wr(DPSA_CTRL_OFS, 32'h1);
    repeat (3) @(posedge sys_clk_in);
    check("debug on", 32'h1, {31'h0, on_chip_debug_circuits_out});
    wr(DPSA_CTRL_OFS, 32'h0);
    stat(32'h05, 32'h0f);
    do_reset(1'b1);
    stat(32'h30, 32'h3e);
    key(1'b1, DPSA_KEY_PAT);
    wr(DPSA_CTRL_OFS, 32'h1);
    stat(32'h20, 32'h2e);
    check("locked debug", 32'h0, {31'h0, on_chip_debug_circuits_out});
    stop_test();
  end
endmodule
bind dpsa_top dpsa_monitor mon (.sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .secure_lock_in, .trace_in, .jtag_req_swd_en_in, .pin_out,
  .pin_oe_out, .jtag_active_out,
  .jtag_scan_en_out, .jtag_trst_b_out, .swd_active_out, .swd_on_usb_out,
  .on_chip_debug_circuits_out);
